// >>> ppc_pkg.sv
/*
 * ppc_pkg: shared constants for the pad pull control block (pin counts,
 * register offsets, control bits, reset values, phase enumeration).
 * Assumes: a 32-bit classic Wishbone register bus with byte addresses.
 */
package ppc_pkg;

  // ****************************************
  // pin population
  // ****************************************
  localparam int PA_PINS = 16;
  localparam int PB_PINS = 16;
  localparam int PC_PINS = 15;
  localparam int NPORT   = 3;

  // ****************************************
  // register bus
  // ****************************************
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_OE   = 8'h10;
  localparam logic [7:0] OFF_IE   = 8'h20;
  localparam logic [7:0] OFF_CARD = 8'h30;
  localparam logic [7:0] OFF_PDX  = 8'h40;
  localparam logic [7:0] OFF_PU   = 8'h50;
  localparam logic [7:0] OFF_PD   = 8'h60;

  localparam int CTRL_POLICY_BIT = 0;
  localparam int CTRL_RUN_BIT    = 1;
  localparam int STAT_RUN_BIT    = 0;

  localparam logic [31:0] RST_PIN_REG = 32'h0000_0000;
  localparam logic        RST_POLICY  = 1'b0;

  typedef enum logic {PH_BOOT, PH_RUN} ppc_phase_t;

endpackage

// >>> ppc_pin_term.sv
/*
 * ppc_pin_term: registered termination and enable decision for one pad.
 * Assumes: inputs are synchronous to clk_i; the hardware reset is rst_i.
 */
`timescale 1ns/10ps
module ppc_pin_term (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  input  wire logic policy_i,
  input  wire logic ie_i,
  input  wire logic oe_i,
  input  wire logic card_i,
  input  wire logic pdx_i,
  output logic      pu_o,
  output logic      pd_o,
  output logic      oe_o,
  output logic      ie_o
);

  // ****************************************
  // termination decision
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // pad three-state: no drive, no pull
      pu_o <= 1'b0; // RULE1
      pd_o <= 1'b0; // RULE1
      oe_o <= 1'b0; // RULE1
      ie_o <= 1'b0;
    end else if (!run_i) begin
      pu_o <= 1'b1; // RULE2
      pd_o <= 1'b0;
      oe_o <= 1'b0;
      ie_o <= 1'b0;
    end else begin
      oe_o <= oe_i; // RULE3
      ie_o <= ie_i; // RULE3
      pd_o <= pdx_i & ~oe_i; // RULE8
      // pull-down pins and card pins never take the pull-up
      pu_o <= ~pdx_i & ~card_i & ~oe_i & (policy_i | ~ie_i); // RULE5 RULE6 RULE7 RULE9
    end
  end

endmodule

// >>> ppc_pad_pull.sv
/*
 * ppc_pad_pull: pull-up / pull-down control for the port A, B and C pads,
 * with per-pin enables, policy and function selects over classic Wishbone.
 * Assumes: one clock clk_i; rst_i follows the hardware reset pin; the pad
 * ring applies the pull and enable levels driven here.
 */
// How it works
// RULE1: hardware reset holds every pad three-state, unpulled
// RULE2: between reset and software start, all pads pull up
// RULE3: once running, pads follow software input/output enables
// RULE4: covers port A 16, B 16, C pins 0-14
// RULE5: policy 0: pull-up only when both enables off
// RULE6: policy 1: pull-up whenever output enable off
// RULE7: once running, card-interface pins never get the pull-up
// RULE8: strobe/select pins pull down when output disabled
// RULE9: pull-down pins never pull up simultaneously
`timescale 1ns/10ps
module ppc_pad_pull
  import ppc_pkg::*;
#(
  parameter int PA_W = ppc_pkg::PA_PINS,
  parameter int PB_W = ppc_pkg::PB_PINS,
  parameter int PC_W = ppc_pkg::PC_PINS,
  parameter int NPIN = PA_W + PB_W + PC_W
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [ppc_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [ppc_pkg::DAT_W-1:0] wb_dat_i,
  output logic      [ppc_pkg::DAT_W-1:0] wb_dat_o,
  output logic                           wb_ack_o,
  output logic      [NPIN-1:0]           pad_pu_o,
  output logic      [NPIN-1:0]           pad_pd_o,
  output logic      [NPIN-1:0]           pad_oe_o,
  output logic      [NPIN-1:0]           pad_ie_o
);
  import ppc_pkg::*;

  // one 32-bit register word per port, so wider ports cannot be served
  if (PA_W < 1 || PA_W > 32 || PB_W < 1 || PB_W > 32 || PC_W < 1 || PC_W > 32 ||
      NPIN != PA_W + PB_W + PC_W) begin : g_bad_width
    $error("ppc_pad_pull: each port needs 1 to 32 pins");
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic int port_w(input int p);
    return (p == 0) ? PA_W : (p == 1) ? PB_W : PC_W;
  endfunction

  function automatic int port_base(input int p);
    return (p == 0) ? 0 : (p == 1) ? PA_W : PA_W + PB_W;
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] base, input int p);
    return adr == 8'(base + 8'(4 * p));
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // ****************************************
  // bus handshake
  // ****************************************
  logic        req;
  logic        wr;
  logic        ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_d;

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr  = req & wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) ack_q <= 1'b0;
    else       ack_q <= req;
  end

  // unmapped offsets answer with zero data and ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i)    dat_q <= 32'h0000_0000;
    else if (req) dat_q <= rd_d;
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ****************************************
  // control: policy and boot phase
  // ****************************************
  logic       policy_q;
  ppc_phase_t phase_q;
  logic       run;

  assign run = (phase_q == PH_RUN);

  always_ff @(posedge clk_i) begin
    if (rst_i)
      policy_q <= RST_POLICY;
    else if (wr && wb_adr_i == OFF_CTRL && wb_sel_i[0])
      policy_q <= wb_dat_i[CTRL_POLICY_BIT];
  end

  // software announces it is running; only reset returns to boot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= PH_BOOT;
    end else begin
      unique case (phase_q)
        PH_BOOT: if (wr && wb_adr_i == OFF_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_RUN_BIT])
                   phase_q <= PH_RUN;
        PH_RUN:  phase_q <= PH_RUN;
      endcase
    end
  end

  // ****************************************
  // per-port pin settings
  // ****************************************
  logic [31:0]     oe_q   [NPORT];
  logic [31:0]     ie_q   [NPORT];
  logic [31:0]     card_q [NPORT];
  logic [31:0]     pdx_q  [NPORT];
  logic [31:0]     pu_rd  [NPORT];
  logic [31:0]     pd_rd  [NPORT];
  logic [NPIN-1:0] oe_vec;
  logic [NPIN-1:0] ie_vec;
  logic [NPIN-1:0] card_vec;
  logic [NPIN-1:0] pdx_vec;

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    localparam int          W    = port_w(p);
    localparam int          BASE = port_base(p);
    localparam logic [31:0] MASK = 32'((64'h1 << W) - 64'h1);

    // bits above the port's last pin stay zero
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        oe_q[p]   <= RST_PIN_REG;
        ie_q[p]   <= RST_PIN_REG;
        card_q[p] <= RST_PIN_REG;
        pdx_q[p]  <= RST_PIN_REG;
      end else if (wr) begin
        if (hit(wb_adr_i, OFF_OE, p))   oe_q[p]   <= merge(oe_q[p], wb_dat_i, wb_sel_i) & MASK; // RULE4
        if (hit(wb_adr_i, OFF_IE, p))   ie_q[p]   <= merge(ie_q[p], wb_dat_i, wb_sel_i) & MASK; // RULE4
        if (hit(wb_adr_i, OFF_CARD, p)) card_q[p] <= merge(card_q[p], wb_dat_i, wb_sel_i) & MASK;
        if (hit(wb_adr_i, OFF_PDX, p))  pdx_q[p]  <= merge(pdx_q[p], wb_dat_i, wb_sel_i) & MASK;
      end
    end

    assign oe_vec[BASE +: W]   = oe_q[p][W-1:0];
    assign ie_vec[BASE +: W]   = ie_q[p][W-1:0];
    assign card_vec[BASE +: W] = card_q[p][W-1:0];
    assign pdx_vec[BASE +: W]  = pdx_q[p][W-1:0];
    assign pu_rd[p]            = 32'(pad_pu_o[BASE +: W]);
    assign pd_rd[p]            = 32'(pad_pd_o[BASE +: W]);
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rd_d = 32'h0000_0000;
    if (wb_adr_i == OFF_CTRL) begin
      rd_d[CTRL_POLICY_BIT] = policy_q;
      rd_d[CTRL_RUN_BIT]    = run;
    end
    if (wb_adr_i == OFF_STAT) rd_d[STAT_RUN_BIT] = run;
    for (int p = 0; p < NPORT; p++) begin
      if (hit(wb_adr_i, OFF_OE, p))   rd_d = oe_q[p];
      if (hit(wb_adr_i, OFF_IE, p))   rd_d = ie_q[p];
      if (hit(wb_adr_i, OFF_CARD, p)) rd_d = card_q[p];
      if (hit(wb_adr_i, OFF_PDX, p))  rd_d = pdx_q[p];
      if (hit(wb_adr_i, OFF_PU, p))   rd_d = pu_rd[p];
      if (hit(wb_adr_i, OFF_PD, p))   rd_d = pd_rd[p];
    end
  end

  // ****************************************
  // pad cells
  // ****************************************
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    ppc_pin_term u_term (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .run_i    (run),
      .policy_i (policy_q),
      .ie_i     (ie_vec[i]),
      .oe_i     (oe_vec[i]),
      .card_i   (card_vec[i]),
      .pdx_i    (pdx_vec[i]),
      .pu_o     (pad_pu_o[i]),
      .pd_o     (pad_pd_o[i]),
      .oe_o     (pad_oe_o[i]),
      .ie_o     (pad_ie_o[i])
    );
  end

  // ****************************************
  // assertions
  // ****************************************
  localparam logic [NPIN-1:0] ALL_ONE = {NPIN{1'b1}};

  a_reset_tristate: assert property (@(posedge clk_i) $past(rst_i) |-> // RULE1
    (pad_pu_o == '0) && (pad_pd_o == '0) && (pad_oe_o == '0))
    else $error("pad not three-state after reset cycle");

  a_boot_pullup: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    ($past(phase_q) == PH_BOOT && !$past(rst_i)) |-> (pad_pu_o == ALL_ONE) && (pad_oe_o == '0))
    else $error("boot phase pull-up missing");

  a_run_enables: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    ($past(run) && !$past(rst_i)) |-> (pad_oe_o == $past(oe_vec)) && (pad_ie_o == $past(ie_vec)))
    else $error("pad enables do not follow software");

  a_port_width: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    ((oe_q[2] >> PC_W) == 32'h0) && ((ie_q[2] >> PC_W) == 32'h0))
    else $error("port C bits beyond last pin set");

  a_policy_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    ($past(run) && !$past(policy_q) && !$past(rst_i)) |->
      pad_pu_o == $past(~oe_vec & ~ie_vec & ~card_vec & ~pdx_vec))
    else $error("policy 0 pull-up wrong");

  a_policy_one: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    ($past(run) && $past(policy_q) && !$past(rst_i)) |->
      pad_pu_o == $past(~oe_vec & ~card_vec & ~pdx_vec))
    else $error("policy 1 pull-up wrong");

  a_card_no_pull: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    ($past(run) && !$past(rst_i)) |-> (pad_pu_o & $past(card_vec)) == '0)
    else $error("pull-up on card-interface pin");

  a_pulldown_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    ($past(run) && !$past(rst_i)) |-> pad_pd_o == $past(pdx_vec & ~oe_vec))
    else $error("pull-down wrong on select pin");

  a_pull_exclusive: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    (pad_pu_o & pad_pd_o) == '0)
    else $error("pull-up and pull-down both on");

  a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not single cycle");

  c_enter_run: cover property (@(posedge clk_i) disable iff (rst_i)
    $past(phase_q) == PH_BOOT && phase_q == PH_RUN);
  c_policy_one: cover property (@(posedge clk_i) disable iff (rst_i)
    run && policy_q && (pad_pu_o & pad_ie_o) != '0);
  c_pulldown: cover property (@(posedge clk_i) disable iff (rst_i) pad_pd_o != '0);

endmodule

// >>> ppc_board_model.sv
/*
 * ppc_board_model: board side of the port pads, resolving each pin's level.
 * Assumes pad controls come from ppc_pad_pull; drv_i is the data driven out.
 */
`timescale 1ns/10ps
module ppc_board_model #(
  parameter int NPIN = 47
) (
  input  wire logic            clk_i,
  input  wire logic [NPIN-1:0] pu_i,
  input  wire logic [NPIN-1:0] pd_i,
  input  wire logic [NPIN-1:0] oe_i,
  input  wire logic [NPIN-1:0] drv_i,
  output logic      [NPIN-1:0] lvl_o
);
  logic [NPIN-1:0] last_q;

  // an undriven, unpulled pin wanders: toggling keeps it from passing as a level
  always @(posedge clk_i) begin
    last_q <= lvl_o;
  end

  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      lvl_o[i] = oe_i[i] ? drv_i[i] : pu_i[i] ? 1'b1 : pd_i[i] ? 1'b0 : ~last_q[i];
    end
  end
endmodule

// >>> tb_top.sv
/*
 * tb_top: table-driven check of the pad pull control through Wishbone.
 * Assumes the design's own assertions run alongside; clock 50 MHz.
 */
`timescale 1ns/10ps
module tb_top;
  import ppc_pkg::*;
  typedef struct {
    logic        pol;
    logic [15:0] oe, ie, cd, px, pu, pd;
  } ppc_row_t;

  logic             clk_i;
  logic             rst_i;
  logic             wb_cyc_i;
  logic             wb_stb_i;
  logic             wb_we_i;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0]       wb_sel_i;
  logic [DAT_W-1:0] wb_dat_i;
  logic [DAT_W-1:0] wb_dat_o;
  logic [DAT_W-1:0] rd_q;
  logic             wb_ack_o;
  logic [46:0]      pad_pu_o;
  logic [46:0]      pad_pd_o;
  logic [46:0]      pad_oe_o;
  logic [46:0]      pad_ie_o;
  logic [46:0]      pin_lvl;
  logic [46:0]      pu_x;
  logic [46:0]      fix_x;
  int               error_cnt = 0;
  int               tests_run = 0;
  ppc_row_t         rows [7];

  ppc_pad_pull ppc_pad_pull_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_pu_o(pad_pu_o),
    .pad_pd_o(pad_pd_o), .pad_oe_o(pad_oe_o), .pad_ie_o(pad_ie_o));

  ppc_board_model ppc_board_model_inst (.clk_i(clk_i), .pu_i(pad_pu_o), .pd_i(pad_pd_o),
    .oe_i(pad_oe_o), .drv_i(47'h0), .lvl_o(pin_lvl));

  // ****************************************
  // helpers
  // ****************************************
  task automatic tally_and_finish;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // ack and read data are taken at the rising edge, before the design updates them
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic pause;
    repeat (2) @(negedge clk_i);
  endtask

  task automatic reset_seq;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk("pads_in_reset", pad_pu_o | pad_pd_o | pad_oe_o | pad_ie_o, 64'h0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    pause();
    chk("boot_pu", pad_pu_o, {47{1'b1}});
    chk("boot_rest", pad_pd_o | pad_oe_o | pad_ie_o, 64'h0);
    chk("boot_lvl", pin_lvl, {47{1'b1}});
  endtask

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    repeat (3000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish();
  end

  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    rst_i    = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    rows[0] = '{1'b0, 16'h0F0F, 16'h3333, 16'h0000, 16'h0000, 16'hC0C0, 16'h0000};
    rows[1] = '{1'b1, 16'h0F0F, 16'h3333, 16'h0000, 16'h0000, 16'hF0F0, 16'h0000};
    rows[2] = '{1'b1, 16'h0F0F, 16'h3333, 16'h00FF, 16'h0000, 16'hF000, 16'h0000};
    rows[3] = '{1'b0, 16'h0F0F, 16'h3333, 16'h0000, 16'h5555, 16'h8080, 16'h5050};
    rows[4] = '{1'b1, 16'h0F0F, 16'h3333, 16'h0000, 16'h5555, 16'hA0A0, 16'h5050};
    rows[5] = '{1'b1, 16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000};
    rows[6] = '{1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'h0000};
    reset_seq();
    // enables and policy written before software start must not reach the pads
    wb(1'b1, OFF_OE, 4'hF, 32'h0000_FFFF);
    wb(1'b1, OFF_CTRL, 4'hF, 32'h0000_0001);
    pause();
    chk("boot_oe", pad_oe_o, 64'h0);
    chk("boot_pu_kept", pad_pu_o, {47{1'b1}});
    wb(1'b1, OFF_OE, 4'h1, 32'h0);
    wb(1'b0, OFF_OE, 4'hF, 32'h0);
    chk("oe_byte_sel", rd_q, 32'h0000_FF00);
    wb(1'b1, OFF_OE + 8'h08, 4'hF, 32'hFFFF_FFFF);
    wb(1'b0, OFF_OE + 8'h08, 4'hF, 32'h0);
    chk("oe_port_c", rd_q, 32'h0000_7FFF);
    wb(1'b1, 8'h80, 4'hF, 32'hFFFF_FFFF);
    wb(1'b0, 8'h80, 4'hF, 32'h0);
    chk("unmapped", rd_q, 32'h0);
    wb(1'b1, OFF_CTRL, 4'hF, 32'h0000_0002);
    wb(1'b0, OFF_STAT, 4'hF, 32'h0);
    chk("run_stat", rd_q, 32'h1);
    foreach (rows[i]) begin
      for (int p = 0; p < 3; p++) begin
        wb(1'b1, OFF_OE + 8'(4 * p), 4'hF, {16'h0, rows[i].oe});
        wb(1'b1, OFF_IE + 8'(4 * p), 4'hF, {16'h0, rows[i].ie});
        wb(1'b1, OFF_CARD + 8'(4 * p), 4'hF, {16'h0, rows[i].cd});
        wb(1'b1, OFF_PDX + 8'(4 * p), 4'hF, {16'h0, rows[i].px});
      end
      wb(1'b1, OFF_CTRL, 4'hF, {30'h0, 1'b1, rows[i].pol});
      pause();
      pu_x  = {rows[i].pu[14:0], rows[i].pu, rows[i].pu};
      fix_x = pu_x | {rows[i].pd[14:0], rows[i].pd, rows[i].pd};
      fix_x = fix_x | {rows[i].oe[14:0], rows[i].oe, rows[i].oe};
      chk("pad_pu", pad_pu_o, {rows[i].pu[14:0], rows[i].pu, rows[i].pu});
      chk("pad_pd", pad_pd_o, {rows[i].pd[14:0], rows[i].pd, rows[i].pd});
      chk("pad_oe", pad_oe_o, {rows[i].oe[14:0], rows[i].oe, rows[i].oe});
      chk("pad_ie", pad_ie_o, {rows[i].ie[14:0], rows[i].ie, rows[i].ie});
      // floating pins wander, so only driven or pulled pins have a known level
      chk("pin_lvl", pin_lvl & fix_x, pu_x);
      wb(1'b0, OFF_PU + 8'h08, 4'hF, 32'h0);
      chk("pu_state_c", rd_q, {17'h0, rows[i].pu[14:0]});
      wb(1'b0, OFF_PD + 8'h08, 4'hF, 32'h0);
      chk("pd_state_c", rd_q, {17'h0, rows[i].pd[14:0]});
    end
    wb(1'b0, OFF_CTRL, 4'hF, 32'h0);
    chk("ctrl_rd", rd_q, 32'h0000_0002);
    // a second reset in mid-run must fall back to the boot pull-up
    reset_seq();
    wb(1'b0, OFF_STAT, 4'hF, 32'h0);
    chk("stat_after_reset", rd_q, 32'h0);
    tally_and_finish();
  end
endmodule
